// ### tts_pkg.sv
package tts_pkg;

  // APB address width and register byte offsets
  localparam int         ADDR_W      = 8;
  localparam logic [7:0] OFS_CTRL    = 8'h00;
  localparam logic [7:0] OFS_STATUS  = 8'h04;
  localparam logic [7:0] OFS_FIRST   = 8'h08;
  localparam logic [7:0] OFS_PERIOD  = 8'h0c;
  localparam logic [7:0] OFS_LEAD    = 8'h10;
  localparam logic [7:0] OFS_GUARD   = 8'h14;
  localparam logic [7:0] OFS_TIME    = 8'h18;
  localparam logic [7:0] OFS_QDATA   = 8'h20;
  localparam logic [7:0] OFS_QEND    = 8'h30;

  // Control field positions
  localparam int CTRL_EN_BIT  = 0;
  localparam int CTRL_IRQ_BIT = 1;

  // Status field positions
  localparam int ST_FLAG_BIT = 0;
  localparam int ST_WIN_BIT  = 1;
  localparam int ST_EN_BIT   = 2;
  localparam int ST_BUSY_BIT = 3;
  localparam int ST_NE_LSB   = 4;
  localparam int ST_FULL_LSB = 8;
  localparam int ST_MISS_LSB = 16;

  // Reset values
  localparam logic [31:0] CTRL_RST   = 32'h0000_0000;
  localparam logic [31:0] FIRST_RST  = 32'h0000_0000;
  localparam logic [31:0] PERIOD_RST = 32'h0000_c350;
  localparam logic [31:0] LEAD_RST   = 32'h0000_0100;
  localparam logic [31:0] GUARD_RST  = 32'h0000_0800;

  // Timing: worst cyclic launch jitter and the clock it is counted in
  localparam int CLK_NS     = 20;
  localparam int JITTER_NS  = 40;
  localparam int JITTER_CYC = (JITTER_NS / CLK_NS < 1) ? 1 : JITTER_NS / CLK_NS;

  // One word of a frame as it travels through queues and the buffer
  typedef struct packed {
    logic        last;
    logic [31:0] data;
  } tts_word_s;

  typedef enum logic {TTS_IDLE, TTS_SEND} tts_state_e;

endpackage

// ### tts_txq.sv
`timescale 1ns/1ps
module tts_txq #(
  parameter int DEPTH = 16,
  parameter int FW    = $clog2(DEPTH + 1)
) (
  // Clock and reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  // Host fill side
  input  wire logic              wr_en,
  input  tts_pkg::tts_word_s     wr_word,
  output logic                   full,
  // Scheduler drain side
  input  wire logic              rd_en,
  output tts_pkg::tts_word_s     rd_word,
  output logic                   empty,
  output logic [FW-1:0]          frames
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_chk
    $error("tts_txq: DEPTH must be a power of two, at least 2");
  end

  tts_pkg::tts_word_s mem [DEPTH];
  logic [AW-1:0]      wp_r;
  logic [AW-1:0]      rp_r;
  logic [AW:0]        cnt_r;
  logic [FW-1:0]      frames_r;

  assign full    = (cnt_r == (AW+1)'(DEPTH));
  assign empty   = (cnt_r == '0);
  assign rd_word = mem[rp_r];
  assign frames  = frames_r;

  // Storage; no reset needed, occupancy guards every read
  always_ff @(posedge pclk) begin
    if (wr_en && !full) begin
      mem[wp_r] <= wr_word;
    end
  end

  // Pointers and occupancy
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wp_r  <= '0;
      rp_r  <= '0;
      cnt_r <= '0;
    end else begin
      if (wr_en && !full) wp_r <= wp_r + AW'(1);
      if (rd_en && !empty) rp_r <= rp_r + AW'(1);
      cnt_r <= cnt_r + (AW+1)'(wr_en && !full) - (AW+1)'(rd_en && !empty);
    end
  end

  // Only whole frames count, so the scheduler never starts a half-written one
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      frames_r <= '0;
    end else begin
      frames_r <= frames_r + FW'(wr_en && !full && wr_word.last)
                           - FW'(rd_en && !empty && rd_word.last);
    end
  end

endmodule // tts_txq

// ### tts_buf2.sv
`timescale 1ns/1ps
module tts_buf2 (
  // Clock and reset
  input  wire logic          pclk,
  input  wire logic          presetn,
  // Fill side
  input  wire logic          in_valid,
  output logic               in_ready,
  input  tts_pkg::tts_word_s in_word,
  // Drain side
  output logic               out_valid,
  input  wire logic          out_ready,
  output tts_pkg::tts_word_s out_word
);

  tts_pkg::tts_word_s d0_r;
  tts_pkg::tts_word_s d1_r;
  logic [1:0]         cnt_r;
  logic               push;
  logic               pop;

  // Ready is plain not-full, so a stall costs no word
  assign in_ready  = (cnt_r != 2'h2);
  assign out_valid = (cnt_r != 2'h0);
  assign out_word  = d0_r;
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // Two entries; head is always d0
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      d0_r  <= '0;
      d1_r  <= '0;
      cnt_r <= 2'h0;
    end else begin
      case ({push, pop})
        2'b10: begin
          if (cnt_r == 2'h0) d0_r <= in_word;
          else d1_r <= in_word;
          cnt_r <= cnt_r + 2'h1;
        end
        2'b01: begin
          d0_r  <= d1_r;
          cnt_r <= cnt_r - 2'h1;
        end
        2'b11: begin
          if (cnt_r == 2'h1) begin
            d0_r <= in_word;
          end else begin
            d0_r <= d1_r;
            d1_r <= in_word;
          end
        end
        default: begin
          cnt_r <= cnt_r;
        end
      endcase
    end
  end

endmodule // tts_buf2

// ### tts_sched.sv
`timescale 1ns/1ps
module tts_sched #(
  parameter int QDEPTH = 16
) (
  // Clock and reset
  input  wire logic                      pclk,
  input  wire logic                      presetn,
  // APB slave
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [tts_pkg::ADDR_W-1:0] paddr,
  input  wire logic [31:0]               pwdata,
  output logic                           pready,
  output logic [31:0]                    prdata,
  output logic                           pslverr,
  // Transmit stream toward the MAC FIFO
  output logic                           tx_valid,
  input  wire logic                      tx_ready,
  output logic [31:0]                    tx_data,
  output logic                           tx_last,
  // Host notification
  output logic                           cyc_insert_irq
);

  localparam int FW  = $clog2(QDEPTH + 1);
  localparam int JIT = tts_pkg::JITTER_CYC;

  if (QDEPTH < 2) begin : g_chk
    $error("tts_sched: QDEPTH must be at least 2");
  end

  // Configuration and state
  logic [31:0]         ctrl_r;
  logic [31:0]         first_r;
  logic [31:0]         period_r;
  logic [31:0]         lead_r;
  logic [31:0]         guard_r;
  logic [31:0]         time_r;
  logic [31:0]         next_trig_r;
  logic                en_d_r;
  logic                win_r;
  logic                flag_r;
  logic [7:0]          miss_r;
  tts_pkg::tts_state_e state_r;
  logic [1:0]          sel_r;
  logic [1:0]          rr_r;

  // Queue and buffer wiring
  logic [3:0]          q_wr;
  logic [3:0]          q_rd;
  logic [3:0]          q_full;
  logic [3:0]          q_empty;
  logic [FW-1:0]       q_frames [4];
  tts_pkg::tts_word_s  q_word [4];
  tts_pkg::tts_word_s  wr_word;
  tts_pkg::tts_word_s  buf_out;
  logic                buf_in_valid;
  logic                buf_in_ready;

  // Decode and scheduling terms
  logic                apb_acc;
  logic                apb_wr;
  logic                is_q;
  logic [1:0]          wq;
  logic                tts_en;
  logic                irq_mode;
  logic                en_rise;
  logic                trig;
  logic                win_open;
  logic [31:0]         remaining;
  logic                room;
  logic                cyc_start;
  logic                acyc_start;
  logic [1:0]          acyc_q;
  logic [3:0]          ready_q;

  assign tts_en   = ctrl_r[tts_pkg::CTRL_EN_BIT];
  assign irq_mode = ctrl_r[tts_pkg::CTRL_IRQ_BIT];
  assign apb_acc  = psel && penable;
  assign apb_wr   = apb_acc && pwrite;
  assign wq       = paddr[3:2];
  assign is_q     = (paddr[7:4] == tts_pkg::OFS_QDATA[7:4]) ||
                    (paddr[7:4] == tts_pkg::OFS_QEND[7:4]);
  assign wr_word  = '{last: (paddr[7:4] == tts_pkg::OFS_QEND[7:4]), data: pwdata};

  // Four queues, one per priority slot; a second port is a second instance
  for (genvar g = 0; g < 4; g++) begin : g_q
    assign q_wr[g] = apb_wr && is_q && (wq == 2'(g)) && !q_full[g];
    assign q_rd[g] = (state_r == tts_pkg::TTS_SEND) && (sel_r == 2'(g)) && buf_in_ready &&
                     !q_empty[g];
    tts_txq #(.DEPTH(QDEPTH)) u_q (
      .pclk    (pclk),
      .presetn (presetn),
      .wr_en   (q_wr[g]),
      .wr_word (wr_word),
      .full    (q_full[g]),
      .rd_en   (q_rd[g]),
      .rd_word (q_word[g]),
      .empty   (q_empty[g]),
      .frames  (q_frames[g])
    );
  end

  // Zero-wait slave; errors for unmapped offsets and writes into a full queue
  always_comb begin
    pready  = 1'b1;
    pslverr = 1'b0;
    prdata  = 32'h0000_0000;
    if (paddr == tts_pkg::OFS_CTRL) begin
      prdata = ctrl_r;
    end else if (paddr == tts_pkg::OFS_STATUS) begin
      prdata[tts_pkg::ST_FLAG_BIT] = flag_r;
      prdata[tts_pkg::ST_WIN_BIT]  = win_r;
      prdata[tts_pkg::ST_EN_BIT]   = tts_en;
      prdata[tts_pkg::ST_BUSY_BIT] = (state_r == tts_pkg::TTS_SEND);
      prdata[tts_pkg::ST_NE_LSB +: 4]   = ~q_empty;
      prdata[tts_pkg::ST_FULL_LSB +: 4] = q_full;
      prdata[tts_pkg::ST_MISS_LSB +: 8] = miss_r;
    end else if (paddr == tts_pkg::OFS_FIRST) begin
      prdata = first_r;
    end else if (paddr == tts_pkg::OFS_PERIOD) begin
      prdata = period_r;
    end else if (paddr == tts_pkg::OFS_LEAD) begin
      prdata = lead_r;
    end else if (paddr == tts_pkg::OFS_GUARD) begin
      prdata = guard_r;
    end else if (paddr == tts_pkg::OFS_TIME) begin
      prdata = time_r;
    end else if (is_q && paddr[1:0] == 2'h0) begin
      pslverr = apb_acc && pwrite && q_full[wq];
    end else begin
      pslverr = apb_acc;
    end
  end

  // Configuration registers; control may change at any time while running
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r   <= tts_pkg::CTRL_RST;
      first_r  <= tts_pkg::FIRST_RST;
      period_r <= tts_pkg::PERIOD_RST;
      lead_r   <= tts_pkg::LEAD_RST;
      guard_r  <= tts_pkg::GUARD_RST;
    end else if (apb_wr) begin
      if (paddr == tts_pkg::OFS_CTRL) begin
        ctrl_r <= pwdata & 32'h0000_0003;
      end else if (paddr == tts_pkg::OFS_FIRST) begin
        first_r <= pwdata;
      end else if (paddr == tts_pkg::OFS_PERIOD) begin
        period_r <= pwdata;
      end else if (paddr == tts_pkg::OFS_LEAD) begin
        lead_r <= pwdata;
      end else if (paddr == tts_pkg::OFS_GUARD) begin
        guard_r <= pwdata;
      end
    end
  end

  // Free-running port time in clock cycles
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) time_r <= 32'h0000_0000;
    else time_r <= time_r + 32'h0000_0001;
  end

  // Exact compare against the running time keeps launches on the cycle
  assign en_rise   = tts_en && !en_d_r;
  assign trig      = tts_en && !en_rise && (time_r == next_trig_r);
  assign win_open  = tts_en && !en_rise && (time_r + lead_r == next_trig_r);
  assign remaining = next_trig_r - time_r;
  assign room      = remaining > guard_r;

  // Trigger schedule: loaded on enable, then advanced one period per trigger
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_d_r      <= 1'b0;
      next_trig_r <= 32'h0000_0000;
    end else begin
      en_d_r <= tts_en;
      if (en_rise) next_trig_r <= first_r;
      else if (trig) next_trig_r <= next_trig_r + period_r;
    end
  end

  // Insert window runs from lead time before a trigger up to the trigger
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) win_r <= 1'b0;
    else if (!tts_en || trig) win_r <= 1'b0;
    else if (win_open) win_r <= 1'b1;
  end

  // Host notification flag; dropped once the host has delivered a cyclic frame
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_r <= 1'b0;
    end else if (win_open && q_frames[0] == '0) begin
      flag_r <= 1'b1;
    end else if (!tts_en || trig || q_frames[0] != '0) begin
      flag_r <= 1'b0;
    end
  end

  // Interrupt mode adds a line on top of the flag
  assign cyc_insert_irq = flag_r && irq_mode;

  // Queues eligible for round-robin service; queue 0 is held back for triggers while enabled
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      ready_q[i] = (q_frames[i] != '0) && (!tts_en || (i != 0 && room));
    end
  end

  // Round-robin pick starting after the last served queue
  always_comb begin
    logic [1:0] k;
    k          = 2'h0;
    acyc_q     = 2'h0;
    acyc_start = 1'b0;
    for (int j = 1; j <= 4; j++) begin
      k = rr_r + 2'(j);
      if (!acyc_start && ready_q[k]) begin
        acyc_q     = k;
        acyc_start = 1'b1;
      end
    end
    if (state_r != tts_pkg::TTS_IDLE || cyc_start) acyc_start = 1'b0;
  end

  // A cyclic frame goes only if queued before its trigger
  assign cyc_start = trig && (state_r == tts_pkg::TTS_IDLE) && (q_frames[0] != '0);

  // Transmit task: the cyclic check comes ahead of the round-robin service and wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= tts_pkg::TTS_IDLE;
      sel_r   <= 2'h0;
      rr_r    <= 2'h3;
    end else begin
      case (state_r)
        tts_pkg::TTS_IDLE: begin
          if (cyc_start) begin
            sel_r   <= 2'h0;
            state_r <= tts_pkg::TTS_SEND;
          end else if (acyc_start) begin
            sel_r   <= acyc_q;
            rr_r    <= acyc_q;
            state_r <= tts_pkg::TTS_SEND;
          end
        end
        tts_pkg::TTS_SEND: begin
          if (q_rd[sel_r] && q_word[sel_r].last) state_r <= tts_pkg::TTS_IDLE;
        end
        default: state_r <= tts_pkg::TTS_IDLE;
      endcase
    end
  end

  // Missed cyclic slots are counted but leave the schedule alone
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) miss_r <= 8'h00;
    else if (trig && !cyc_start && miss_r != 8'hff) miss_r <= miss_r + 8'h01;
  end

  // Frame words pass a two-entry buffer so a stalled link drops nothing
  assign buf_in_valid = (state_r == tts_pkg::TTS_SEND) && !q_empty[sel_r];
  tts_buf2 u_buf (
    .pclk      (pclk),
    .presetn   (presetn),
    .in_valid  (buf_in_valid),
    .in_ready  (buf_in_ready),
    .in_word   (q_word[sel_r]),
    .out_valid (tx_valid),
    .out_ready (tx_ready),
    .out_word  (buf_out)
  );
  assign tx_data = buf_out.data;
  assign tx_last = buf_out.last;

  // Checks
  property p_cyc_at_trig;
    @(posedge pclk) disable iff (!presetn)
    cyc_start |=> (state_r == tts_pkg::TTS_SEND) && (sel_r == 2'h0);
  endproperty
  a_cyc_at_trig: assert property (p_cyc_at_trig) else $error("cyclic frame not started");

  property p_skip_empty;
    @(posedge pclk) disable iff (!presetn)
    (trig && q_frames[0] == '0) |=> !((state_r == tts_pkg::TTS_SEND) && (sel_r == 2'h0));
  endproperty
  a_skip_empty: assert property (p_skip_empty) else $error("cyclic sent with empty queue");

  property p_acyc_room;
    @(posedge pclk) disable iff (!presetn)
    (acyc_start && tts_en) |-> (remaining > guard_r) && (acyc_q != 2'h0);
  endproperty
  a_acyc_room: assert property (p_acyc_room) else $error("acyclic started without room");

  property p_flag_set;
    @(posedge pclk) disable iff (!presetn)
    (win_open && q_frames[0] == '0) |=> flag_r && win_r;
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("insert flag not set");

  property p_flag_clr;
    @(posedge pclk) disable iff (!presetn)
    (flag_r && !win_open && (trig || q_frames[0] != '0)) |=> !flag_r;
  endproperty
  a_flag_clr: assert property (p_flag_clr) else $error("insert flag not cleared");

  property p_irq;
    @(posedge pclk) disable iff (!presetn)
    $rose(flag_r) && irq_mode |-> cyc_insert_irq;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt missing");

  property p_period;
    @(posedge pclk) disable iff (!presetn)
    (trig && !en_rise) |=> next_trig_r == $past(next_trig_r) + $past(period_r);
  endproperty
  a_period: assert property (p_period) else $error("trigger period wrong");

  property p_first;
    @(posedge pclk) disable iff (!presetn)
    en_rise |=> next_trig_r == $past(first_r);
  endproperty
  a_first: assert property (p_first) else $error("first trigger not loaded");

  property p_serve;
    @(posedge pclk) disable iff (!presetn)
    (!tts_en && state_r == tts_pkg::TTS_IDLE && q_frames[1] != '0) |=>
      state_r == tts_pkg::TTS_SEND;
  endproperty
  a_serve: assert property (p_serve) else $error("waiting frame not served");

  property p_launch;
    @(posedge pclk) disable iff (!presetn)
    (cyc_start && buf_in_ready) |-> ##[1:JIT] buf_in_valid;
  endproperty
  a_launch: assert property (p_launch) else $error("cyclic launch late");

  c_cyc:  cover property (@(posedge pclk) disable iff (!presetn) cyc_start);
  c_acyc: cover property (@(posedge pclk) disable iff (!presetn) acyc_start && tts_en);
  c_flag: cover property (@(posedge pclk) disable iff (!presetn) $fell(flag_r) && !trig);
  c_miss: cover property (@(posedge pclk) disable iff (!presetn) trig && !cyc_start);

endmodule // tts_sched

// ### tts_sink.sv
`timescale 1ns/1ps
// Stand-in for the MAC transmit FIFO: takes words and logs each with a cycle stamp
module tts_sink (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // Stream from the scheduler
  input  wire logic        tx_valid,
  output logic             tx_ready,
  input  wire logic [31:0] tx_data,
  input  wire logic        tx_last,
  // Pace control from the bench
  input  wire logic        slow
);
  logic [31:0]        cyc_r;
  tts_pkg::tts_word_s got_q[$];
  logic [31:0]        at_q[$];

  initial tx_ready = 1'b1;

  // Free cycle count on the same reset as the block's own time base
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cyc_r <= 32'h0;
    end else begin
      cyc_r <= cyc_r + 32'h1;
    end
  end

  // Slow mode stalls two cycles in three, so the two-entry buffer really fills
  always @(posedge pclk) begin
    tx_ready <= !slow || (cyc_r % 3 == 0);
  end

  // Log each accepted word with the cycle it was taken in
  always @(posedge pclk) begin
    if (presetn && tx_valid && tx_ready) begin
      got_q.push_back('{last: tx_last, data: tx_data});
      at_q.push_back(cyc_r);
    end
  end
endmodule // tts_sink

// ### tts_sched_test.sv
`timescale 1ns/1ps
module tts_sched_test;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, tx_data, r, t, t_ofs, first;
  logic        tx_valid, tx_ready, tx_last, cyc_insert_irq, slow, e;
  int          n_errors, samples_checked;

  tts_sched #(.QDEPTH(16)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .tx_valid(tx_valid), .tx_ready(tx_ready),
    .tx_data(tx_data), .tx_last(tx_last), .cyc_insert_irq(cyc_insert_irq));
  tts_sink sink (.pclk(pclk), .presetn(presetn), .tx_valid(tx_valid), .tx_ready(tx_ready),
    .tx_data(tx_data), .tx_last(tx_last), .slow(slow));

  always #10 pclk = ~pclk;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One APB transfer; the idle edge at entry keeps back-to-back calls clean
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    chk(32'(n < 50), 32'h1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
    chk(32'(e), 32'h0);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(r, exp);
  endtask

  // Push a frame of n words; only the last goes through the end-of-frame port
  task automatic push(input int q, input logic [31:0] base, input int n);
    for (int i = 0; i < n; i++) begin
      wr((i == n - 1 ? tts_pkg::OFS_QEND : tts_pkg::OFS_QDATA) + 8'(4 * q), base + 32'(i));
    end
  endtask

  // Bounded wait for the next logged word, then compare data, last and return its stamp
  task automatic expect_word(input logic [31:0] d, input logic l);
    int n;
    n = 0;
    while (sink.got_q.size() == 0 && n < 600) begin
      @(posedge pclk);
      n++;
    end
    chk(32'(sink.got_q.size() != 0), 32'h1);
    if (sink.got_q.size() != 0) begin
      chk(sink.got_q[0].data, d);
      chk(32'(sink.got_q[0].last), 32'(l));
      t = sink.at_q.pop_front() + t_ofs;
      void'(sink.got_q.pop_front());
    end
  endtask

  // Poll the status word until the insert flag shows, at most 100 reads
  task automatic wait_flag;
    int n;
    n = 0;
    do begin
      apb(1'b0, tts_pkg::OFS_STATUS, 32'h0);
      n++;
    end while (r[tts_pkg::ST_FLAG_BIT] !== 1'b1 && n < 100);
    chk(32'(r[tts_pkg::ST_FLAG_BIT]), 32'h1);
  endtask

  task automatic give_verdict;
    $display("checks=%0d mismatches=%0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // Watchdog: the whole sequence needs well under 5000 cycles
  initial begin
    repeat (20000) @(posedge pclk);
    n_errors++;
    $display("[FAIL] t=%0t watchdog got=%h exp=%h", $time, 32'h1, 32'h0);
    give_verdict();
  end

  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    slow = 1'b0;
    t_ofs = 32'h0;
    n_errors = 0;
    samples_checked = 0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    // Reset values, status readable, unmapped offset refused
    rd_chk(tts_pkg::OFS_CTRL, tts_pkg::CTRL_RST);
    rd_chk(tts_pkg::OFS_FIRST, tts_pkg::FIRST_RST);
    rd_chk(tts_pkg::OFS_PERIOD, tts_pkg::PERIOD_RST);
    rd_chk(tts_pkg::OFS_LEAD, tts_pkg::LEAD_RST);
    rd_chk(tts_pkg::OFS_GUARD, tts_pkg::GUARD_RST);
    rd_chk(tts_pkg::OFS_STATUS, 32'h0);
    apb(1'b1, 8'h40, 32'h1);
    chk(32'(e), 32'h1);
    $display("test reset_values done");
    // Plain service of all four queues while the receiver stalls
    slow <= 1'b1;
    push(1, 32'ha100, 3);
    push(3, 32'ha300, 1);
    for (int i = 0; i < 3; i++) begin
      expect_word(32'ha100 + 32'(i), i == 2);
    end
    expect_word(32'ha300, 1'b1);
    push(0, 32'hb000, 1);
    push(2, 32'hb200, 2);
    expect_word(32'hb000, 1'b1);
    expect_word(32'hb200, 1'b0);
    expect_word(32'hb201, 1'b1);
    slow <= 1'b0;
    $display("test acyclic_stall done");
    // Time-triggered send: program before enabling, then run three cycles
    wr(tts_pkg::OFS_PERIOD, 32'd200);
    wr(tts_pkg::OFS_LEAD, 32'd40);
    wr(tts_pkg::OFS_GUARD, 32'd60);
    apb(1'b0, tts_pkg::OFS_TIME, 32'h0);
    t_ofs = r - sink.cyc_r;
    first = r + 32'd150;
    wr(tts_pkg::OFS_FIRST, first);
    wr(tts_pkg::OFS_CTRL, 32'h1);
    wait_flag();
    chk(32'(cyc_insert_irq), 32'h0);
    chk(32'(r[tts_pkg::ST_EN_BIT]), 32'h1);
    push(0, 32'hc000, 1);
    // Flag gone, window still open, enabled, queue 0 holding the frame
    rd_chk(tts_pkg::OFS_STATUS, 32'h0000_0016);
    expect_word(32'hc000, 1'b1);
    chk(t, first + 32'd2);
    // Second cycle: interrupt mode, queue 0 left empty, acyclic word waits
    wait_flag();
    wr(tts_pkg::OFS_CTRL, 32'h3);
    apb(1'b0, tts_pkg::OFS_STATUS, 32'h0);
    chk(32'(cyc_insert_irq), 32'h1);
    push(1, 32'hc100, 1);
    expect_word(32'hc100, 1'b1);
    chk(32'(t > first + 32'd200), 32'h1);
    apb(1'b0, tts_pkg::OFS_STATUS, 32'h0);
    chk(32'(r[tts_pkg::ST_FLAG_BIT]), 32'h0);
    chk(32'(cyc_insert_irq), 32'h0);
    chk(32'(r[tts_pkg::ST_MISS_LSB +: 8]), 32'h1);
    // Third cycle: schedule kept despite the skipped trigger
    push(0, 32'hc200, 1);
    expect_word(32'hc200, 1'b1);
    chk(t, first + 32'd402);
    // Switch off at run time: queue 0 is served at once
    wr(tts_pkg::OFS_CTRL, 32'h0);
    apb(1'b0, tts_pkg::OFS_STATUS, 32'h0);
    chk(32'(r[tts_pkg::ST_EN_BIT]), 32'h0);
    push(0, 32'hc300, 1);
    expect_word(32'hc300, 1'b1);
    chk(32'(t < first + 32'd600), 32'h1);
    $display("test time_triggered done");
    // A queue fed words but no frame end is never served, so it fills up
    for (int i = 0; i < 16; i++) begin
      wr(tts_pkg::OFS_QDATA + 8'h08, 32'(i));
    end
    apb(1'b1, tts_pkg::OFS_QDATA + 8'h08, 32'h0);
    chk(32'(e), 32'h1);
    rd_chk(tts_pkg::OFS_STATUS, 32'h0001_0440);
    $display("test queue_full done");
    give_verdict();
  end
endmodule // tts_sched_test
